// File: core/barrier_pkg.sv
// Constants, state codes and error codes of the lane barrier sequencer.
// Assumes a single 100 MHz core clock and synchronous inputs.

`default_nettype none

package barrier_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_W     = 24;
  localparam int unsigned TIME_W         = 8;

  // ---------------------------------------------------------------
  // Pulse queue
  // ---------------------------------------------------------------
  localparam int unsigned QUEUE_DEPTH = 5;
  localparam int unsigned QCOUNT_W    = 3;
  localparam logic        DIR_ENTRY   = 1'b0;
  localparam logic        DIR_EXIT    = 1'b1;

  // ---------------------------------------------------------------
  // Bus straps
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W            = 3;
  localparam int unsigned SW_TERM_BIT       = 0;
  localparam int unsigned SW_ADDR_LSB       = 1;
  localparam logic        LOGIC_TERM        = 1'b1;
  localparam logic [2:0]  LOGIC_ADDR        = 3'h0;
  localparam logic [2:0]  MOTOR_MASTER_ADDR = 3'h0;
  localparam logic [2:0]  MOTOR_SLAVE_ADDR  = 3'h7;

  // ---------------------------------------------------------------
  // Error codes, two decimal digits packed as nibbles
  // ---------------------------------------------------------------
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_EMERG    = 8'h02;
  localparam logic [7:0] ERR_BREAKIN  = 8'h04;
  localparam logic [7:0] ERR_IMPACT   = 8'h05;
  localparam logic [7:0] ERR_ANGLE    = 8'h40;
  localparam logic [7:0] ERR_CAN_ADDR = 8'h62;

  typedef enum logic [3:0] {
    ST_HOME_OPEN  = 4'h0,
    ST_HOME_CLOSE = 4'h1,
    ST_IDLE       = 4'h2,
    ST_OPEN       = 4'h3,
    ST_PASS       = 4'h4,
    ST_CLEAR      = 4'h5,
    ST_CLOSING    = 4'h6,
    ST_OOS        = 4'h7,
    ST_EMERG      = 4'h8,
    ST_CFG_ERR    = 4'h9
  } state_t;

endpackage

`default_nettype wire

// File: core/pulse_queue.sv
// Five-entry first-in first-out store of opening-pulse directions.
// Assumes the caller never pushes when it has no use for a pulse.

`timescale 1ns/10ps
`default_nettype none

module pulse_queue
  import barrier_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                push_i,
  input  wire logic                din_i,
  input  wire logic                pop_i,
  input  wire logic                flush_i,
  output logic                     dout_o,
  output logic                     empty_o,
  output logic                     full_o,
  output logic [QCOUNT_W-1:0]      count_o
);
  import barrier_pkg::*;

  typedef struct packed {
    logic [QUEUE_DEPTH-1:0] mem;
    logic [QCOUNT_W-1:0]    head;
    logic [QCOUNT_W-1:0]    count;
  } fifo_t;

  fifo_t q;
  fifo_t n;
  logic  push_ok;
  logic  pop_ok;

  function automatic logic [QCOUNT_W-1:0] wrap_idx(input logic [3:0] v);
    if (v >= 4'(QUEUE_DEPTH))
      return QCOUNT_W'(v - 4'(QUEUE_DEPTH));
    return v[QCOUNT_W-1:0];
  endfunction

  always_comb
  begin
    n       = q;
    push_ok = push_i && (q.count != QCOUNT_W'(QUEUE_DEPTH));
    pop_ok  = pop_i && (q.count != '0);
    if (flush_i)
    begin
      n.head  = '0;
      n.count = '0;
    end
    else
    begin
      if (push_ok)
        n.mem[wrap_idx({1'b0, q.head} + {1'b0, q.count})] = din_i;
      if (pop_ok)
        n.head = wrap_idx({1'b0, q.head} + 4'h1);
      n.count = QCOUNT_W'(q.count + {2'b0, push_ok} - {2'b0, pop_ok});
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= '0;
    else
      q <= n;
  end

  assign dout_o  = q.mem[q.head];
  assign empty_o = (q.count == '0);
  assign full_o  = (q.count == QCOUNT_W'(QUEUE_DEPTH));
  assign count_o = q.count;

endmodule // pulse_queue

`default_nettype wire

// File: core/barrier_passage_sequencer.sv
// Passage sequencer of a motorised pedestrian lane barrier.
// Assumes synchronous inputs; photocell inputs are high while blocked.

`timescale 1ns/10ps
`default_nettype none

module barrier_passage_sequencer
  import barrier_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = barrier_pkg::TICK_CYCLES
)
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic                    emergency_input_i,
  input  wire logic                    entry_opening_input_i,
  input  wire logic                    exit_opening_input_i,
  input  wire logic                    entry_enable_i,
  input  wire logic                    exit_enable_i,
  input  wire logic                    queue_enable_i,
  input  wire logic                    reclose_behaviour_select_i,
  input  wire logic                    impact_response_select_i,
  input  wire logic [TIME_W-1:0]       hold_time_i,
  input  wire logic [TIME_W-1:0]       safety_delay_i,
  input  wire logic                    photocell_a_i,
  input  wire logic                    photocell_b_i,
  input  wire logic                    inner_limit_i,
  input  wire logic                    outer_limit_i,
  input  wire logic                    angle_ok_i,
  input  wire logic                    impact_i,
  input  wire logic                    closed_displaced_i,
  input  wire logic [3:0]              cfg_switch_i,
  input  wire logic [ADDR_W-1:0]       motor_master_addr_i,
  input  wire logic [ADDR_W-1:0]       motor_slave_addr_i,
  output logic                         motor_power_o,
  output logic                         wing_open_cmd_o,
  output logic                         wing_close_cmd_o,
  output logic                         reduced_speed_o,
  output logic                         out_of_service_o,
  output logic                         break_in_alarm_o,
  output logic [7:0]                   error_code_o,
  output logic                         error_relay_o,
  output logic                         can_term_en_o,
  output logic [ADDR_W-1:0]            can_addr_o,
  output logic                         entry_inhibit_o,
  output logic                         exit_inhibit_o,
  output logic                         entry_red_cross_o,
  output logic                         exit_red_cross_o,
  output logic [2:0]                   input_led_o,
  output logic [2:0]                   relay_led_o
);
  import barrier_pkg::*;

  typedef struct packed {
    state_t                st;
    logic [PRESCALE_W-1:0] pre;
    logic [TIME_W-1:0]     tmr;
    logic                  dir;
    logic                  breakin;
    logic                  impact;
    logic [7:0]            err;
    logic                  ent_prev;
    logic                  ext_prev;
    logic [3:0]            cfg;
    logic [2:0]            in_led;
  } seq_t;

  localparam seq_t SEQ_RESET = '{st: ST_HOME_OPEN, default: '0};

  seq_t                q;
  seq_t                n;
  logic                q_push;
  logic                q_din;
  logic                q_pop;
  logic                q_flush;
  logic                q_dout;
  logic                q_empty;
  logic                q_full;
  logic [QCOUNT_W-1:0] q_count;
  logic                tick;
  logic                cell_any;
  logic                cell_both;
  logic                cfg_bad;
  logic                fault_st;
  logic                queue_mode;
  logic                ent_ok;
  logic                ext_ok;
  logic                ok;

  pulse_queue u_queue (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .push_i     (q_push),
    .din_i      (q_din),
    .pop_i      (q_pop),
    .flush_i    (q_flush),
    .dout_o     (q_dout),
    .empty_o    (q_empty),
    .full_o     (q_full),
    .count_o    (q_count)
  );

  // ---------------------------------------------------------------
  // Decode of the inputs and the registered state
  // ---------------------------------------------------------------
  assign cell_any   = photocell_a_i | photocell_b_i;
  assign cell_both  = photocell_a_i & photocell_b_i;
  assign queue_mode = queue_enable_i & entry_enable_i & exit_enable_i;
  assign tick       = (q.pre == PRESCALE_W'(TICK_CYCLES_P - 1));
  assign fault_st   = (q.st == ST_EMERG) || (q.st == ST_OOS) ||
                      (q.st == ST_CFG_ERR) || (q.st == ST_HOME_OPEN) ||
                      (q.st == ST_HOME_CLOSE);
  // The switch straps are caught by the clock, so a moving switch is seen late; the motor addresses are not.
  assign cfg_bad    = (q.cfg[SW_TERM_BIT] != LOGIC_TERM) ||
                      (q.cfg[SW_ADDR_LSB +: ADDR_W] != LOGIC_ADDR) ||
                      (motor_master_addr_i == motor_slave_addr_i) ||
                      (motor_master_addr_i != MOTOR_MASTER_ADDR) ||
                      (motor_slave_addr_i != MOTOR_SLAVE_ADDR);
  assign ok         = !cfg_bad && emergency_input_i && (q.st != ST_OOS);

  // While one direction is served, the far reader is held off.
  assign entry_inhibit_o = !entry_enable_i || fault_st ||
                           (q.st != ST_IDLE && q.dir != DIR_ENTRY);
  assign exit_inhibit_o  = !exit_enable_i || fault_st ||
                           (q.st != ST_IDLE && q.dir != DIR_EXIT);
  assign ent_ok = entry_opening_input_i && !q.ent_prev && !entry_inhibit_o;
  assign ext_ok = exit_opening_input_i && !q.ext_prev && !exit_inhibit_o;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    n        = q;
    q_pop    = 1'b0;
    q_flush  = 1'b0;
    q_din    = ent_ok ? DIR_ENTRY : DIR_EXIT;
    n.ent_prev = entry_opening_input_i;
    n.ext_prev = exit_opening_input_i;
    n.cfg      = cfg_switch_i;
    n.in_led   = {exit_opening_input_i, entry_opening_input_i,
                  emergency_input_i};
    n.pre      = tick ? '0 : PRESCALE_W'(q.pre + 1'b1);
    if (tick && q.tmr != '0)
      n.tmr = TIME_W'(q.tmr - 1'b1);
    // A pulse is stored only when it can be used.
    q_push = (ent_ok || ext_ok) &&
             (queue_mode || (q.st == ST_IDLE && q_empty));
    n.breakin = closed_displaced_i &&
                (q.breakin || q.st == ST_IDLE);

    case (q.st)
      ST_HOME_OPEN:
        if (outer_limit_i)
          n.st = angle_ok_i ? ST_HOME_CLOSE : ST_OOS;
      ST_HOME_CLOSE:
        if (inner_limit_i)
          n.st = ST_IDLE;
      ST_IDLE:
        if (!q_empty)
        begin
          q_pop    = 1'b1;
          n.dir    = q_dout;
          n.tmr    = hold_time_i;
          n.impact = 1'b0;
          n.st     = ST_OPEN;
        end
      ST_OPEN:
        if (cell_any)
          n.st = ST_PASS;
        else if (q.tmr == '0)
        begin
          if (!q_empty)
          begin
            q_pop = 1'b1;
            n.dir = q_dout;
            n.tmr = hold_time_i;
          end
          else
            n.st = ST_CLOSING;
        end
      ST_PASS:
        if (cell_both)
        begin
          n.tmr = safety_delay_i;
          n.st  = ST_CLEAR;
        end
      ST_CLEAR:
        if (q.tmr == '0 && !cell_any)
        begin
          if (!q_empty)
          begin
            q_pop = 1'b1;
            n.dir = q_dout;
            n.tmr = hold_time_i;
            n.st  = ST_OPEN;
          end
          else
            n.st = ST_CLOSING;
        end
      ST_CLOSING:
        if (impact_i)
        begin
          n.impact = 1'b1;
          if (impact_response_select_i)
          begin
            n.tmr = hold_time_i;
            n.st  = ST_OPEN;
          end
        end
        else if (cell_any && reclose_behaviour_select_i)
        begin
          n.tmr = hold_time_i;
          n.st  = ST_OPEN;
        end
        else if (inner_limit_i)
          n.st = ST_IDLE;
      ST_OOS:
        n.st = ST_OOS;
      ST_EMERG:
        if (emergency_input_i)
          n.st = ST_HOME_OPEN;
      ST_CFG_ERR:
        if (!cfg_bad)
          n.st = ST_HOME_OPEN;
      default:
        n.st = ST_HOME_OPEN;
    endcase

    if (q.st != ST_OOS)
    begin
      if (cfg_bad)
      begin
        n.st    = ST_CFG_ERR;
        q_flush = 1'b1;
      end
      else if (!emergency_input_i)
      begin
        n.st    = ST_EMERG;
        q_flush = 1'b1;
      end
    end

    if (n.st == ST_OOS)
      n.err = ERR_ANGLE;
    else if (cfg_bad)
      n.err = ERR_CAN_ADDR;
    else if (!emergency_input_i)
      n.err = ERR_EMERG;
    else if (n.breakin)
      n.err = ERR_BREAKIN;
    else if (n.impact)
      n.err = ERR_IMPACT;
    else
      n.err = ERR_NONE;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= SEQ_RESET;
    else
      q <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign motor_power_o     = (q.st != ST_EMERG) && (q.st != ST_CFG_ERR);
  assign wing_open_cmd_o   = (q.st == ST_HOME_OPEN) || (q.st == ST_OPEN) ||
                             (q.st == ST_PASS) || (q.st == ST_CLEAR);
  assign wing_close_cmd_o  = (q.st == ST_HOME_CLOSE) || (q.st == ST_CLOSING);
  assign reduced_speed_o   = (q.st == ST_HOME_CLOSE);
  assign out_of_service_o  = (q.st == ST_OOS);
  assign break_in_alarm_o  = q.breakin;
  assign error_code_o      = q.err;
  assign error_relay_o     = (q.err == ERR_NONE);
  assign can_term_en_o     = q.cfg[SW_TERM_BIT];
  assign can_addr_o        = q.cfg[SW_ADDR_LSB +: ADDR_W];
  assign entry_red_cross_o = entry_inhibit_o && (q.st != ST_EMERG);
  assign exit_red_cross_o  = exit_inhibit_o && (q.st != ST_EMERG);
  assign input_led_o       = q.in_led;
  assign relay_led_o       = {error_relay_o, exit_inhibit_o,
                              entry_inhibit_o};

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_short_homing;
    q.st == ST_HOME_OPEN && outer_limit_i && !angle_ok_i && ok;
  endsequence

  sequence s_stuck_oos;
    (q.st == ST_OOS && out_of_service_o && !error_relay_o) [*4];
  endsequence

  a_homing_angle_oos: assert property (s_short_homing |=> s_stuck_oos)
    else $error("short homing travel did not latch out-of-service");

  a_emerg_power_cut: assert property (
    (!emergency_input_i && !cfg_bad && q.st != ST_OOS)
      |=> !motor_power_o && wing_open_cmd_o == 1'b0)
    else $error("motor power not removed after emergency loss");

  a_hold_expire_close: assert property (
    (q.st == ST_OPEN && q.tmr == '0 && !cell_any && q_empty && ok)
      |=> q.st == ST_CLOSING)
    else $error("hold-open expiry did not close the lane");

  a_both_blocked_clear: assert property (
    (q.st == ST_PASS && cell_both && ok)
      |=> q.st == ST_CLEAR && q.tmr == $past(safety_delay_i))
    else $error("hold time not cleared when both cells blocked");

  a_clear_no_delay: assert property (
    (q.st == ST_CLEAR && q.tmr == '0 && !cell_any && q_empty && ok)
      |=> q.st == ST_CLOSING)
    else $error("wings did not close once cells were clear");

  a_delay_holds_open: assert property (
    (q.st == ST_CLEAR && q.tmr != '0 && ok) |=> q.st == ST_CLEAR)
    else $error("closing began before the safety delay expired");

  a_reclose_reopen: assert property (
    (q.st == ST_CLOSING && cell_any && !impact_i &&
     reclose_behaviour_select_i && ok)
      |=> q.st == ST_OPEN ##1 wing_open_cmd_o)
    else $error("blocked cell during closing did not reopen");

  a_queue_bound: assert property (q_count <= QCOUNT_W'(QUEUE_DEPTH))
    else $error("pulse queue holds more than five entries");

  a_relay_on_error: assert property (
    (!emergency_input_i && !cfg_bad) |=> !error_relay_o ##1 !error_relay_o
      || emergency_input_i)
    else $error("error relay stayed energised during an error");

  a_far_side_inhibit: assert property (
    (q.st == ST_OPEN && q.dir == DIR_ENTRY) |-> exit_inhibit_o)
    else $error("far reader not inhibited during entry passage");

endmodule // barrier_passage_sequencer

`default_nettype wire

// File: verif/wing_drive_model.sv
// Wing drive model: moves the wings one step a cycle while a motor
// command is on. Assumes one clock shared with the sequencer.
`timescale 1ns/10ps
`default_nettype none
module wing_drive_model #(
  parameter int TRAVEL = 10
)
(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic motor_power_i,
  input  wire logic open_cmd_i,
  input  wire logic close_cmd_i,
  output logic      inner_limit_o,
  output logic      outer_limit_o
);
  int pos_q;
  // Wings start half open, so homing must travel both ways.
  // Without motor power the springs pull the wings open.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pos_q <= TRAVEL / 2;
    else if ((!motor_power_i || open_cmd_i) && pos_q < TRAVEL)
      pos_q <= pos_q + 1;
    else if (motor_power_i && close_cmd_i && pos_q > 0)
      pos_q <= pos_q - 1;
  end
  assign inner_limit_o = (pos_q == 0);
  assign outer_limit_o = (pos_q == TRAVEL);
endmodule // wing_drive_model
`default_nettype wire

// File: verif/barrier_passage_sequencer_bench.sv
// Bench of the lane barrier passage sequencer and a wing drive model.
// Assumes the package, the sequencer and the model compile first.
`timescale 1ns/10ps
`default_nettype none
module barrier_passage_sequencer_bench;
  import barrier_pkg::*;
  localparam int TICK = 4;
  localparam int W_OPEN = 0, W_CLOSE = 1, W_RED = 2, W_INNER = 3, W_OOS = 4;
  logic              core_clk, rstn, emerg, entry_op, exit_op, queue_en;
  logic              reclose, imp_sel, pa, pb, inner, outer, angle_ok;
  logic              impact, displaced, pwr, open_cmd, close_cmd, reduced;
  logic              oos, brk, relay, term, x_inh, x_cross, e_inh, e_cross;
  logic [TIME_W-1:0] hold, sdelay;
  logic [3:0]        cfg;
  logic [ADDR_W-1:0] m_addr, s_addr, can_addr;
  logic [7:0]        err;
  logic [2:0]        in_led, r_led;
  logic [3:0]        bad_cfg [4] = '{4'h0, 4'h3, 4'h1, 4'h1};
  logic [2:0]        bad_m [4] = '{3'h0, 3'h0, 3'h0, 3'h1};
  logic [2:0]        bad_s [4] = '{3'h7, 3'h7, 3'h0, 3'h7};
  int                num_errors, total_checks;

  barrier_passage_sequencer #(.TICK_CYCLES_P(TICK)) dut_u (
    .core_clk_i(core_clk), .rstn_i(rstn), .emergency_input_i(emerg),
    .entry_opening_input_i(entry_op), .exit_opening_input_i(exit_op),
    .entry_enable_i(1'b1), .exit_enable_i(1'b1), .queue_enable_i(queue_en),
    .reclose_behaviour_select_i(reclose), .impact_response_select_i(imp_sel),
    .hold_time_i(hold), .safety_delay_i(sdelay), .photocell_a_i(pa),
    .photocell_b_i(pb), .inner_limit_i(inner), .outer_limit_i(outer),
    .angle_ok_i(angle_ok), .impact_i(impact), .closed_displaced_i(displaced),
    .cfg_switch_i(cfg), .motor_master_addr_i(m_addr),
    .motor_slave_addr_i(s_addr), .motor_power_o(pwr),
    .wing_open_cmd_o(open_cmd), .wing_close_cmd_o(close_cmd),
    .reduced_speed_o(reduced), .out_of_service_o(oos),
    .break_in_alarm_o(brk), .error_code_o(err), .error_relay_o(relay),
    .can_term_en_o(term), .can_addr_o(can_addr), .entry_inhibit_o(e_inh),
    .exit_inhibit_o(x_inh), .entry_red_cross_o(e_cross),
    .exit_red_cross_o(x_cross), .input_led_o(in_led), .relay_led_o(r_led));

  wing_drive_model wing_u (
    .core_clk_i(core_clk), .rstn_i(rstn), .motor_power_i(pwr),
    .open_cmd_i(open_cmd), .close_cmd_i(close_cmd),
    .inner_limit_o(inner), .outer_limit_o(outer));

  always #5 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      W_OPEN:  return open_cmd;
      W_CLOSE: return close_cmd;
      W_RED:   return reduced;
      W_INNER: return inner;
      default: return oos;
    endcase
  endfunction

  // A wait that runs out of cycles fails its check and ends the run.
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(8'(pick(s)), 8'(v));
    if (n >= lim)
      final_report();
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cells(input logic a, input logic b);
    @(posedge core_clk);
    pa <= a;
    pb <= b;
  endtask

  task automatic pulse_entry();
    @(posedge core_clk);
    entry_op <= 1'b1;
    @(posedge core_clk);
    entry_op <= 1'b0;
  endtask

  task automatic home();
    wait_for(W_RED, 1'b1, 100);
    wait_for(W_INNER, 1'b1, 100);
    step(2);
    chk(8'(reduced), 8'h00);
  endtask

  task automatic passage(input int dly, input logic re);
    @(posedge core_clk);
    sdelay <= TIME_W'(dly);
    reclose <= re;
    pulse_entry();
    wait_for(W_OPEN, 1'b1, 6);
    chk(8'({x_inh, x_cross}), 8'h03);
    cells(1'b1, 1'b0);
    cells(1'b1, 1'b1);
    if (dly == 0)
    begin
      step(40);
      chk(8'(close_cmd), 8'h00);
    end
    cells(1'b0, 1'b0);
    if (dly == 0)
      wait_for(W_CLOSE, 1'b1, 4);
    else
    begin
      step(2);
      chk(8'(close_cmd), 8'h00);
      wait_for(W_CLOSE, 1'b1, 20);
    end
    cells(1'b1, 1'b0);
    // A reopened lane waits for a new passage, so both cells block again.
    if (re)
    begin
      wait_for(W_OPEN, 1'b1, 4);
      cells(1'b1, 1'b1);
    end
    else
    begin
      step(3);
      chk(8'(open_cmd), 8'h00);
    end
    cells(1'b0, 1'b0);
    wait_for(W_INNER, 1'b1, 300);
    step(3);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    emerg = 1'b1;
    entry_op = 1'b0;
    exit_op = 1'b0;
    queue_en = 1'b0;
    reclose = 1'b0;
    imp_sel = 1'b1;
    pa = 1'b0;
    pb = 1'b0;
    angle_ok = 1'b1;
    impact = 1'b0;
    displaced = 1'b0;
    hold = 8'h05;
    sdelay = 8'h00;
    cfg = 4'h1;
    m_addr = 3'h0;
    s_addr = 3'h7;
    num_errors = 0;
    total_checks = 0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    home();
    chk(8'({relay, pwr, term, can_addr}), 8'h38);
    chk(8'(in_led), 8'h01);
    chk(8'({r_led, e_inh, e_cross}), 8'h10);
    @(posedge core_clk);
    displaced <= 1'b1;
    step(3);
    chk(8'({brk, relay}), 8'h02);
    chk(err, ERR_BREAKIN);
    @(posedge core_clk);
    displaced <= 1'b0;
    step(3);
    chk(8'(brk), 8'h00);
    passage(0, 1'b1);
    passage(3, 1'b0);
    pulse_entry();
    wait_for(W_CLOSE, 1'b1, 4 * TICK * 6 + 20);
    @(posedge core_clk);
    impact <= 1'b1;
    @(posedge core_clk);
    impact <= 1'b0;
    wait_for(W_OPEN, 1'b1, 4);
    chk(err, ERR_IMPACT);
    wait_for(W_INNER, 1'b1, 300);
    passage(0, 1'b0);
    chk(err, ERR_NONE);
    // Two stored pulses: after the first passage the lane must stay open.
    @(posedge core_clk);
    queue_en <= 1'b1;
    pulse_entry();
    pulse_entry();
    cells(1'b1, 1'b0);
    cells(1'b1, 1'b1);
    cells(1'b0, 1'b0);
    step(3);
    chk(8'({open_cmd, close_cmd}), 8'h02);
    wait_for(W_CLOSE, 1'b1, 4 * TICK * 6 + 20);
    wait_for(W_INNER, 1'b1, 300);
    @(posedge core_clk);
    queue_en <= 1'b0;
    @(posedge core_clk);
    emerg <= 1'b0;
    step(3);
    chk(8'({pwr, relay}), 8'h00);
    chk(err, ERR_EMERG);
    chk(8'({e_inh, x_inh, e_cross, x_cross}), 8'h0C);
    @(posedge core_clk);
    emerg <= 1'b1;
    home();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      cfg <= bad_cfg[i];
      m_addr <= bad_m[i];
      s_addr <= bad_s[i];
      step(3);
      chk(8'({term, can_addr}), 8'({bad_cfg[i][0], bad_cfg[i][3:1]}));
      chk(8'({err[6:0], pwr}), 8'({ERR_CAN_ADDR[6:0], 1'b0}));
    end
    @(posedge core_clk);
    cfg <= 4'h1;
    m_addr <= 3'h0;
    s_addr <= 3'h7;
    home();
    @(posedge core_clk);
    angle_ok <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    wait_for(W_OOS, 1'b1, 100);
    chk(8'({err[6:0], relay}), 8'({ERR_ANGLE[6:0], 1'b0}));
    @(posedge core_clk);
    angle_ok <= 1'b1;
    step(30);
    chk(8'(oos), 8'h01);
    final_report();
  end
endmodule // barrier_passage_sequencer_bench
`default_nettype wire
